// >>> design/pgecc_pkg.sv
// Package for the page layout and power-up initialisation block.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package pgecc_pkg;

  // ************************************************************
  // Page layout
  // ************************************************************
  localparam int ADDR_W = 13;                       // Byte address width
  localparam logic [12:0] MAIN_LAST = 13'h0fff;     // Last main byte
  localparam logic [12:0] SECTOR_BYTES = 13'h0200;  // Main sector size
  localparam logic [12:0] BBM_FIRST = 13'h1000;     // Bad-block marker
  localparam logic [12:0] BBM_LAST = 13'h1003;
  localparam logic [12:0] META2_FIRST = 13'h1004;   // Unprotected meta
  localparam logic [12:0] META2_LAST = 13'h103f;
  localparam logic [12:0] META1_FIRST = 13'h1040;   // Protected meta
  localparam logic [12:0] META1_LAST = 13'h107f;
  localparam logic [12:0] CODE_FIRST = 13'h1080;    // Correction code
  localparam logic [12:0] CODE_LAST = 13'h10ff;
  localparam logic [12:0] PAGE_LAST = 13'h10ff;     // Last decoded byte
  localparam int PROT_BYTES = 544;                  // Bytes per codeword
  localparam int MAX_FIX = 8;                       // Correctable bits
  localparam logic [7:0] BAD_MARK = 8'h00;          // Factory bad mark
  localparam logic [7:0] ERASED = 8'hff;            // Good block value
  localparam int TOTAL_BLOCKS = 2048;
  localparam int MIN_VALID_BLOCK_COUNT = 2008;

  // ************************************************************
  // Timing and reset values
  // ************************************************************
  localparam int CLK_MHZ = 100;
  localparam int INIT_TIME_US_X100 = 125000;       // 1.25 ms in 10 ns
  localparam int INIT_CYCLES = INIT_TIME_US_X100 * CLK_MHZ / 100;
  localparam bit ECC_EN_RESET = 1'b1;              // Default after power
  localparam int STATUS_BUSY_BIT = 0;              // Busy flag position

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    PGECC_MAIN, PGECC_BBM, PGECC_META2, PGECC_META1, PGECC_CODE,
    PGECC_NONE
  } pgecc_region_type;

  typedef struct packed {
    pgecc_region_type region;  // Area the byte falls in
    logic [2:0] sector;        // Owning sector
    logic isProtected;         // Covered by correction
  } pgecc_map_type;

  typedef struct packed {
    logic valid;               // Request strobe
    logic [12:0] addr;         // Page byte address
  } pgecc_req_type;

endpackage

// >>> design/pgecc_addr_map.sv
// Combinational decode of a page byte address into its area.
// Assumes addresses up to 10FFh; above that reads as no area.
`timescale 1ns/1ps
`default_nettype none
module pgecc_addr_map (
  // Address in
  input wire logic [12:0] addr,
  // Decode out
  output pgecc_pkg::pgecc_map_type map
);
  import pgecc_pkg::*;

  // ************************************************************
  // Area decode
  // ************************************************************
  always_comb begin
    map = '{region: PGECC_NONE, sector: 3'h0, isProtected: 1'b0};
    if (addr <= MAIN_LAST) begin
      // Eight 512-byte sectors
      map.region = PGECC_MAIN;
      map.sector = addr[11:9];
      map.isProtected = 1'b1;
    end else if (addr <= BBM_LAST) begin
      // Marker bytes stay outside coverage
      map.region = PGECC_BBM;
    end else if (addr <= META2_LAST) begin
      // Four-byte groups, unprotected
      map.region = PGECC_META2;
      map.sector = addr[4:2];
    end else if (addr <= META1_LAST) begin
      // Eight bytes per sector, protected
      map.region = PGECC_META1;
      map.sector = addr[5:3];
      map.isProtected = 1'b1;
    end else if (addr <= CODE_LAST) begin
      // Sixteen code bytes per sector
      map.region = PGECC_CODE;
      map.sector = addr[6:4];
      map.isProtected = 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> design/pgecc_init.sv
// Power-up sequencer and page-layout classifier of the flash core.
// Assumes srst models supply crossing the write-inhibit level and
// that the array side answers a page-load request with pageDone.
`timescale 1ns/1ps
`default_nettype none
module pgecc_init #(
  parameter int BLOCKS = pgecc_pkg::TOTAL_BLOCKS,
  parameter int MIN_VALID = pgecc_pkg::MIN_VALID_BLOCK_COUNT,
  parameter int INIT_WAIT = pgecc_pkg::INIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic powerUp,
  // Software reset command and correction enable write
  input wire logic resetCmd,
  input wire logic eccWrite,
  input wire logic eccWriteValue,
  // Array side
  input wire logic pageDone,
  input wire logic [3:0] errorBits,
  output logic pageLoad,
  // Layout query
  input wire pgecc_pkg::pgecc_req_type query,
  output pgecc_pkg::pgecc_map_type queryMap,
  output logic queryValid,
  // Marker check
  input wire logic [7:0] markerByte,
  output logic blockBad,
  // Status
  output logic [7:0] status,
  output logic eccEnable,
  output logic uncorrectable,
  output logic cachePreloaded
);
  import pgecc_pkg::*;

  // Assertions below all run on clk and sleep through reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Refuse a timer or block count the logic cannot serve
  if (INIT_WAIT < 1 || MIN_VALID > BLOCKS) begin : g_bad_param
    $error("bad parameters");
  end

  // ************************************************************
  // State
  // ************************************************************
  typedef enum {IDLE, LOAD, WAIT, READY} pgecc_phase_type;

  typedef struct packed {
    pgecc_phase_type phase;
    logic [31:0] count;          // Initialisation timer
    logic eccEn;                 // Correction enable
    logic load;                  // Page load strobe
    logic busy;                  // Operation in progress flag
    logic preloaded;
    logic uncorr;
    logic bad;
    pgecc_map_type qmap;
    logic qvalid;
  } pgecc_state_type;

  pgecc_state_type st, next_st;
  pgecc_map_type decoded;        // Decoder output

  pgecc_addr_map mapper (.addr(query.addr), .map(decoded));

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_st = st;
    next_st.load = 1'b0;
    next_st.qmap = decoded;
    next_st.qvalid = query.valid;
    next_st.bad = (markerByte != ERASED);
    if (eccWrite) next_st.eccEn = eccWriteValue;
    unique case (st.phase)
      IDLE: begin
        // Starts on a powerUp request or a reset command
        if (powerUp || resetCmd) begin
          next_st.phase = LOAD;
          next_st.busy = 1'b1;
          next_st.load = 1'b1;
          next_st.count = '0;
        end
      end
      LOAD: begin
        next_st.count = st.count + 32'd1;
        if (pageDone) begin
          next_st.preloaded = 1'b1;
          // More than eight flips is beyond repair
          next_st.uncorr = st.eccEn && (errorBits > 4'(MAX_FIX));
          next_st.phase = WAIT;
        end
      end
      WAIT: begin
        // Ready no later than the host's fixed wait
        next_st.busy = 1'b0;
        next_st.phase = READY;
      end
      READY: begin
        // Reset reloads page but keeps enable
        if (resetCmd) begin
          next_st.phase = LOAD;
          next_st.busy = 1'b1;
          next_st.load = 1'b1;
          next_st.preloaded = 1'b0;
          // Fresh timer, else a reload inherits the old count
          next_st.count = '0;
        end
      end
    endcase
    // Timer guards a stuck array load
    if (st.phase == LOAD && st.count >= 32'(INIT_WAIT - 1))
      next_st.phase = WAIT;
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '{phase: IDLE, count: 32'h0, eccEn: ECC_EN_RESET,
              load: 1'b0, busy: 1'b1, preloaded: 1'b0,
              uncorr: 1'b0, bad: 1'b0,
              qmap: '{region: PGECC_NONE, sector: 3'h0,
                      isProtected: 1'b0}, qvalid: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign pageLoad = st.load;
  assign queryMap = st.qmap;
  assign queryValid = st.qvalid;
  assign blockBad = st.bad;
  assign status = {7'h00, st.busy};
  assign eccEnable = st.eccEn;
  assign uncorrectable = st.uncorr;
  assign cachePreloaded = st.preloaded;

  // ************************************************************
  // Checks
  // ************************************************************
  // Power-up request seen while idle
  sequence s_start;
    st.phase == IDLE && powerUp;
  endsequence

  // Array answer seen while the first page loads
  sequence s_answer;
    st.phase == LOAD && pageDone;
  endsequence

  // Input-driven checks skip the edge where reset lets go, since
  // the registers still hold reset values one edge later

  // Power-up raises busy and asks for the first page
  a_busy_at_start: assert property (s_start |=> st.busy && st.load)
    else $error("no busy");

  // A finished load always marks the cache as filled
  a_preload_done: assert property (s_answer |=> st.preloaded)
    else $error("no preload");

  // Busy drops on the edge after the wait phase
  a_ready_clears: assert property (st.phase == WAIT |=> !st.busy)
    else $error("busy stuck");

  // A reset command leaves the enable alone
  a_ecc_kept: assert property (
    !srst && resetCmd && !eccWrite |=> st.eccEn == $past(st.eccEn))
    else $error("enable lost");

  // Main bytes map to the sector of address bits 11:9
  a_main_sector: assert property (
    !srst && query.addr <= MAIN_LAST |=> st.qmap.region == PGECC_MAIN &&
    st.qmap.sector == $past(query.addr[11:9]))
    else $error("bad sector");

  // Marker bytes sit outside correction
  a_marker_open: assert property (
    !srst && query.addr inside {[BBM_FIRST:BBM_LAST]} |=>
    st.qmap.region == PGECC_BBM && !st.qmap.isProtected)
    else $error("marker covered");

  // Secondary metadata is never covered
  a_meta_two: assert property (
    !srst && query.addr inside {[META2_FIRST:META2_LAST]} |=>
    st.qmap.region == PGECC_META2 && !st.qmap.isProtected)
    else $error("meta II wrong");

  // Primary metadata is covered with its sector
  a_meta_one: assert property (
    !srst && query.addr inside {[META1_FIRST:META1_LAST]} |=>
    st.qmap.region == PGECC_META1 && st.qmap.isProtected)
    else $error("meta I wrong");

  // Code bytes owned by sector of address bits 6:4
  a_code_sector: assert property (
    !srst && query.addr inside {[CODE_FIRST:CODE_LAST]} |=>
    st.qmap.sector == $past(query.addr[6:4]))
    else $error("code sector");

  // A factory mark always reads as a bad block
  a_bad_mark: assert property (
    !srst && markerByte == BAD_MARK |=> st.bad)
    else $error("mark missed");
endmodule
`default_nettype wire

// >>> verif/pgecc_array_model.sv
// Array-side model: answers a first-page load with a done pulse.
// Assumes the bench sets the flip count and the answer delay.
`timescale 1ns/1ps
`default_nettype none
module pgecc_array_model (
  // Clock
  input wire logic clk,
  // Load request and bench controls
  input wire logic pageLoad,
  input wire logic [3:0] flips,
  input wire logic [7:0] delay,
  // Answer
  output logic pageDone = 1'b0,
  output logic [3:0] errorBits = 4'h0
);
  int cnt = -1; // Cycles left, -1 when idle
  // Count down, then answer once; count is junk outside the answer
  always @(posedge clk) begin
    pageDone <= 1'b0;
    errorBits <= ~flips;
    if (pageLoad) begin
      cnt <= delay;
    end else if (cnt == 0) begin
      pageDone <= 1'b1;
      errorBits <= flips;
      cnt <= -1;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// >>> verif/pgecc_init_tb_top.sv
// Self-checking bench of the power-up sequencer and layout decode.
// Assumes the array model answers loads; short init wait of 20.
`timescale 1ns/1ps
`default_nettype none
module pgecc_init_tb_top;
  import pgecc_pkg::*;
  // *****
  // Stimulus and observed signals
  // *****
  logic clk = 1'b0, srst = 1'b1, powerUp = 1'b0, resetCmd = 1'b0;
  logic eccWrite = 1'b0, eccWriteValue = 1'b0, pageDone, pageLoad;
  logic [3:0] errorBits, flips = 4'h0;
  logic [7:0] delay = 8'h03, markerByte = 8'hff, status;
  pgecc_req_type query = '0;
  pgecc_map_type queryMap;
  logic queryValid, blockBad, eccEnable, uncorrectable, cachePreloaded;
  int errCount = 0, numChecks = 0, cycles = 0;

  // Short load timer so the stuck-array case ends quickly
  localparam int INIT_WAIT_SIM = 20;
  pgecc_init #(.INIT_WAIT(INIT_WAIT_SIM)) dut (.clk(clk), .srst(srst),
    .powerUp(powerUp), .resetCmd(resetCmd), .eccWrite(eccWrite),
    .eccWriteValue(eccWriteValue), .pageDone(pageDone),
    .errorBits(errorBits), .pageLoad(pageLoad), .query(query),
    .queryMap(queryMap), .queryValid(queryValid),
    .markerByte(markerByte), .blockBad(blockBad), .status(status),
    .eccEnable(eccEnable), .uncorrectable(uncorrectable),
    .cachePreloaded(cachePreloaded));
  pgecc_array_model arr (.clk(clk), .pageLoad(pageLoad), .flips(flips),
    .delay(delay), .pageDone(pageDone), .errorBits(errorBits));

  // 100 MHz clock
  always #5 clk = ~clk;

  // Hang guard, far above the 150 or so cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errCount++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expected decode, worked out from the page layout
  function automatic pgecc_map_type expMap(input logic [12:0] a);
    if (a <= MAIN_LAST) return '{PGECC_MAIN, a[11:9], 1'b1};
    if (a <= BBM_LAST) return '{PGECC_BBM, 3'h0, 1'b0};
    if (a <= META2_LAST) return '{PGECC_META2, a[4:2], 1'b0};
    if (a <= META1_LAST) return '{PGECC_META1, a[5:3], 1'b1};
    if (a <= CODE_LAST) return '{PGECC_CODE, a[6:4], 1'b1};
    return '{PGECC_NONE, 3'h0, 1'b0};
  endfunction

  // Bounded wait for busy to drop, then judge the load outcome
  task automatic awaitReady(input logic expUnc);
    for (int i = 0; i < 200 && status[0] !== 1'b0; i++)
      @(posedge clk);
    #1;
    chk(status, 8'h00);
    chk(cachePreloaded, 1'b1);
    chk(uncorrectable, expUnc);
  endtask

  task automatic powerUpTest();
    chk(pageLoad, 1'b0);
    chk(status, 8'h01);
    chk(eccEnable, 1'b1);
    @(posedge clk) powerUp <= 1'b1;
    @(posedge clk) powerUp <= 1'b0;
    #1 chk(pageLoad, 1'b1);
    chk({status, cachePreloaded}, 9'h002);
    awaitReady(1'b0);
  endtask

  // Enable write, then reset command; the setting must survive it
  task automatic reloadTest(input logic ecc, input logic [3:0] n,
                            input logic expUnc);
    @(posedge clk) begin
      eccWrite <= 1'b1;
      eccWriteValue <= ecc;
      flips <= n;
      delay <= 8'h0c;
    end
    @(posedge clk) begin
      eccWrite <= 1'b0;
      resetCmd <= 1'b1;
    end
    @(posedge clk) resetCmd <= 1'b0;
    #1 chk({pageLoad, eccEnable}, {1'b1, ecc});
    awaitReady(expUnc);
  endtask

  // Back-to-back queries across every area edge
  task automatic mapTest();
    logic [12:0] a[18] = '{13'h0000, 13'h01ff, 13'h0200, 13'h0e00,
      13'h0fff, 13'h1000, 13'h1003, 13'h1004, 13'h101c, 13'h103f,
      13'h1040, 13'h1078, 13'h107f, 13'h1080, 13'h10f0, 13'h10ff,
      13'h1100, 13'h1fff};
    pgecc_map_type e;
    for (int i = 0; i <= 18; i++) begin
      @(posedge clk) query <= '{i < 18, (i < 18) ? a[i] : 13'h0000};
      #1;
      if (i > 0) begin
        e = expMap(a[i-1]);
        chk({queryValid, queryMap.region, queryMap.isProtected},
            {1'b1, e.region, e.isProtected});
        if (e.region != PGECC_NONE) chk(queryMap.sector, e.sector);
      end
    end
  endtask

  task automatic markerTest();
    logic [7:0] v[4] = '{8'h00, 8'hff, 8'h5a, 8'hfe};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) markerByte <= v[i];
      @(posedge clk) #1 chk(blockBad, v[i] != ERASED);
    end
  endtask

  // Array never answers: the load timer alone must end busy
  task automatic stuckTest();
    int n;
    n = 0;
    @(posedge clk) delay <= 8'hff;
    @(posedge clk) resetCmd <= 1'b1;
    @(posedge clk) resetCmd <= 1'b0;
    #1;
    while (status[0] === 1'b1 && n < 100) begin
      @(posedge clk) #1;
      n++;
    end
    chk(16'(n), 16'(INIT_WAIT_SIM + 1));
    chk(cachePreloaded, 1'b0);
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk); // Host quiet while supply settles
    srst <= 1'b0;
    #1;
    powerUpTest();
    mapTest();
    markerTest();
    reloadTest(1'b1, 4'h8, 1'b0);
    reloadTest(1'b1, 4'h9, 1'b1);
    reloadTest(1'b0, 4'hf, 1'b0);
    reloadTest(1'b1, 4'h0, 1'b0);
    stuckTest();
    tally_and_finish();
  end
endmodule
`default_nettype wire
